// [ksm_pkg.sv]
// Constants for the key stream field XOR mapper.
// Assumes a 32-bit APB master and a 100 MHz pclk.
package ksm_pkg;
    // APB register byte offsets
    localparam logic [7:0] KSM_CTRL_OFS = 8'h00;
    localparam logic [7:0] KSM_BLEN_OFS = 8'h04;
    localparam logic [7:0] KSM_FRAME_OFS = 8'h08;
    localparam logic [7:0] KSM_STAT_OFS = 8'h0C;
    // Control, frame and status register field positions
    localparam int KSM_CTRL_EN = 0;
    localparam int KSM_CTRL_DBL = 1;
    localparam int KSM_CTRL_FMT_LO = 2;
    localparam int KSM_FRAME_FN_LO = 0;
    localparam int KSM_FRAME_MFN_LO = 4;
    localparam int KSM_STAT_SEG = 16;
    localparam int KSM_STAT_ACT = 17;
    // Field geometry
    localparam logic [10:0] KSM_TAIL_BITS = 11'h028;
    localparam logic [10:0] KSM_DBL_SEG_LEN = 11'h348;
    localparam logic [10:0] KSM_SUB_DATA = 11'h040;
    localparam logic [10:0] KSM_SUB_LEN = 11'h050;
    localparam logic [10:0] KSM_SINGLE_DATA = 11'h300;
    localparam logic [10:0] KSM_BLEN_RST = 11'h050;
    // B-field layouts
    typedef enum logic [1:0] {
        KSM_FMT_UNPROT = 2'b00,
        KSM_FMT_MULTI = 2'b01,
        KSM_FMT_SINGLE = 2'b10,
        KSM_FMT_RSVD = 2'b11
    } ksm_fmt_type;
endpackage

// [ksm_mapper.sv]
// Key stream to D-field XOR mapper for half, long and double slot bearers.
// Assumes the key stream generator presents one key bit beside every D-field
// bit, and MAC framing delivers tail bits a8..a47 then B-field bits serially.
`timescale 1ns/1ps

// Functional notes
// - Half/long segment is 40 plus j bits
// - Ciphered tail: key bits 0-39 onto a8-a47
// - Other tail: key bits 0-39 discarded
// - Unprotected half/long: key 40+ onto B bits
// - Protected half/long: skip 104-119, resume at 120
// - Frame stream splits into two segments
// - Double slot segments are 840 bits
// - Double unprotected: key 40-839 onto 800 bits
// - Double single-subfield: 768 data bits ciphered only
// - Ten subfields of 80 bits, then X
// - Per subfield 64 ciphered, 16 skipped
// - Checks and X-field pass unmodified
// - Each bearer ciphered with own initialization value
// - Transmit: first field first segment, second second
// - Receive: first field first segment, second second
// - Connection cipher mode applies to all bearers
// - Related connections share one cipher mode
// - Half/long B0: 64 data, 16 check
module ksm_mapper (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Framing side
    input wire logic frame_start,
    input wire logic field_start,
    input wire logic tail_ct,
    input wire logic [3:0] bearer_id,
    input wire logic d_valid,
    input wire logic d_bit,
    output logic q_valid,
    output logic q_bit,
    output logic field_done,
    // Key stream generator side
    input wire logic ks_bit,
    output logic ks_take,
    output logic ks_segment,
    output logic [31:0] init_value
);
    import ksm_pkg::*;

    typedef struct packed {
        logic en;
        logic dbl;
        logic [1:0] fmt;
        logic [10:0] blen;
        logic [3:0] fn;
        logic [23:0] mfn;
        logic act;
        logic tail_l;
        logic ciph;
        logic dbl_l;
        logic [1:0] fmt_l;
        logic [10:0] blen_l;
        logic seg;
        logic seen;
        logic [10:0] idx;
        logic [6:0] sub;
        logic q_bit;
        logic q_valid;
        logic done;
        logic [15:0] fcnt;
        logic [31:0] rdata;
        logic err;
        logic [31:0] iv;
    } ksm_state_type;

    ksm_state_type s_q, s_d;

    logic [10:0] seg_len;
    logic [10:0] b_idx;
    logic in_seg;
    logic in_b;
    logic key_hit;
    logic setup;
    logic access;
    logic addr_ok;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign addr_ok = (paddr == KSM_CTRL_OFS) || (paddr == KSM_BLEN_OFS) ||
                     (paddr == KSM_FRAME_OFS) || (paddr == KSM_STAT_OFS);

    // Segment length and B-field bit position of the current bit
    assign seg_len = s_q.dbl_l ? KSM_DBL_SEG_LEN : 11'(KSM_TAIL_BITS + s_q.blen_l);
    assign in_seg = s_q.act && (s_q.idx < seg_len);
    assign in_b = s_q.idx >= KSM_TAIL_BITS;
    assign b_idx = 11'(s_q.idx - KSM_TAIL_BITS);

    // One mapping serves both directions, so deciphering inverts ciphering
    // Reserved format keys no B-field bit, a safe state for a half-programmed mode
    always_comb begin
        key_hit = 1'b0;
        if (!in_b) begin
            key_hit = s_q.tail_l;
        end else begin
            unique case (s_q.fmt_l)
                KSM_FMT_UNPROT: key_hit = 1'b1;
                KSM_FMT_MULTI: begin
                    if (s_q.dbl_l) begin
                        key_hit = {4'h0, s_q.sub} < KSM_SUB_DATA;
                    end else begin
                        key_hit = (b_idx < KSM_SUB_DATA) || (b_idx >= KSM_SUB_LEN);
                    end
                end
                KSM_FMT_SINGLE: key_hit = b_idx < KSM_SINGLE_DATA;
                KSM_FMT_RSVD: key_hit = 1'b0;
            endcase
        end
    end

    // Key bits are consumed for every position of the segment, used or not.
    // A bit offered beside field_start is dropped, so it must not eat key either,
    // or the generator and the mapper would fall out of step for the whole field.
    assign ks_take = d_valid && in_seg && !field_start;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.q_valid = 1'b0;
        // APB: read data captured in setup, write takes effect in access
        // Registering the decode in setup keeps pslverr off the late address path
        if (setup) begin
            s_d.err = !addr_ok;
            unique case (paddr)
                KSM_CTRL_OFS: s_d.rdata = {28'h0000000, s_q.fmt, s_q.dbl, s_q.en};
                KSM_BLEN_OFS: s_d.rdata = {21'h000000, s_q.blen};
                KSM_FRAME_OFS: s_d.rdata = {4'h0, s_q.mfn, s_q.fn};
                KSM_STAT_OFS: s_d.rdata = {14'h0000, s_q.act, s_q.seg, s_q.fcnt};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
        if (access && pwrite) begin
            unique case (paddr)
                KSM_CTRL_OFS: begin
                    s_d.en = pwdata[KSM_CTRL_EN];
                    s_d.dbl = pwdata[KSM_CTRL_DBL];
                    s_d.fmt = pwdata[KSM_CTRL_FMT_LO +: 2];
                end
                KSM_BLEN_OFS: s_d.blen = pwdata[10:0];
                KSM_FRAME_OFS: begin
                    s_d.fn = pwdata[KSM_FRAME_FN_LO +: 4];
                    s_d.mfn = pwdata[KSM_FRAME_MFN_LO +: 24];
                end
                default: s_d.err = s_q.err;
            endcase
        end
        // The frame boundary rearms the first segment
        if (frame_start) begin
            s_d.seen = 1'b0;
        end
        if (field_start) begin
            // First field of a frame takes the first segment, the next the second
            s_d.seg = s_q.seen && !frame_start;
            s_d.seen = 1'b1;
            s_d.act = 1'b1;
            s_d.idx = 11'h000;
            s_d.sub = 7'h00;
            s_d.tail_l = tail_ct;
            // Mode sampled per field so every bearer of the connection follows it
            s_d.ciph = s_q.en;
            s_d.dbl_l = s_q.dbl;
            s_d.fmt_l = s_q.fmt;
            s_d.blen_l = s_q.blen;
            // The bearer number keeps the key streams of parallel bearers apart
            s_d.iv = {bearer_id, s_q.mfn, s_q.fn};
        end else if (d_valid) begin
            s_d.q_valid = 1'b1;
            s_d.q_bit = d_bit ^ (ks_bit && in_seg && key_hit && s_q.ciph);
            if (s_q.act) begin
                s_d.idx = 11'(s_q.idx + 11'h001);
                if (in_b) begin
                    s_d.sub = ({4'h0, s_q.sub} == 11'(KSM_SUB_LEN - 11'h001)) ? 7'h00 : 7'(s_q.sub + 7'h01);
                end
                if (11'(s_q.idx + 11'h001) == seg_len) begin
                    s_d.act = 1'b0;
                    s_d.done = 1'b1;
                    s_d.fcnt = 16'(s_q.fcnt + 16'h0001);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            // A half slot length keeps the first field sane before software writes j
            s_q.blen <= KSM_BLEN_RST;
            s_q.blen_l <= KSM_BLEN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pready = access;
    assign pslverr = access && s_q.err;
    assign q_valid = s_q.q_valid;
    assign q_bit = s_q.q_bit;
    assign field_done = s_q.done;
    assign ks_segment = s_q.seg;
    assign init_value = s_q.iv;

    // All checks sample on pclk and rest while the connection is in reset
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_tail_cipher: assert property (
        d_valid && !field_start && in_seg && !in_b && s_q.tail_l && s_q.ciph
        |=> q_valid && q_bit == ($past(d_bit) ^ $past(ks_bit)))
        else $error("ciphered tail bit not keyed");
    chk_tail_clear: assert property (
        d_valid && !field_start && !in_b && !s_q.tail_l |=> q_bit == $past(d_bit))
        else $error("plain tail bit modified");
    chk_half_skip: assert property (
        d_valid && !field_start && in_seg && !s_q.dbl_l && s_q.fmt_l == KSM_FMT_MULTI && in_b &&
        b_idx >= KSM_SUB_DATA && b_idx < KSM_SUB_LEN |-> ks_take ##1 q_bit == $past(d_bit))
        else $error("half slot check bits keyed");
    chk_single_tail: assert property (
        d_valid && !field_start && s_q.fmt_l == KSM_FMT_SINGLE && in_b && b_idx >= KSM_SINGLE_DATA
        |=> q_bit == $past(d_bit))
        else $error("single subfield check keyed");
    chk_multi_check: assert property (
        d_valid && !field_start && s_q.dbl_l && s_q.fmt_l == KSM_FMT_MULTI && in_b &&
        {4'h0, s_q.sub} >= KSM_SUB_DATA |=> q_bit == $past(d_bit))
        else $error("subfield check keyed");
    chk_unprot_key: assert property (
        d_valid && !field_start && in_seg && in_b && s_q.ciph && s_q.fmt_l == KSM_FMT_UNPROT
        |=> q_bit == ($past(d_bit) ^ $past(ks_bit)))
        else $error("unprotected bit not keyed");

    // Segment bookkeeping
    chk_seg_len: assert property (
        s_q.act |-> s_q.idx < (s_q.dbl_l ? KSM_DBL_SEG_LEN : 11'(KSM_TAIL_BITS + s_q.blen_l)))
        else $error("key taken beyond segment");
    chk_first_seg: assert property (
        field_start && (frame_start || !s_q.seen) |=> !ks_segment)
        else $error("first field not on first segment");
    chk_second_seg: assert property (
        field_start && s_q.seen && !frame_start |=> ks_segment)
        else $error("second field not on second segment");
    chk_mode_hold: assert property (
        s_q.act && !field_start |=> $stable(s_q.ciph))
        else $error("cipher mode changed mid field");
    chk_iv_load: assert property (
        field_start |=> init_value[31:28] == $past(bearer_id) && init_value[27:4] == $past(s_q.mfn))
        else $error("bearer initialization value wrong");
    chk_iv_hold: assert property (
        !field_start |=> $stable(init_value))
        else $error("initialization value moved mid field");
    chk_seg_hold: assert property (
        !field_start |=> $stable(ks_segment))
        else $error("segment select moved mid field");
    chk_idx_reset: assert property (
        field_start |=> s_q.act && s_q.idx == 11'h000)
        else $error("field start did not restart segment");
    chk_dbl_end: assert property (
        d_valid && !field_start && s_q.act && s_q.dbl_l && s_q.idx == 11'(KSM_DBL_SEG_LEN - 11'h001)
        |=> field_done)
        else $error("double slot segment end missed");
    chk_half_end: assert property (
        d_valid && !field_start && s_q.act && !s_q.dbl_l && s_q.idx == 11'(KSM_TAIL_BITS + s_q.blen_l - 11'h001)
        |=> field_done)
        else $error("half slot segment end missed");
    chk_done_once: assert property (
        field_done |=> !field_done)
        else $error("field done longer than one cycle");
    chk_fcnt_step: assert property (
        field_done |-> s_q.fcnt == 16'($past(s_q.fcnt) + 16'h0001))
        else $error("finished field count wrong");

    // Bit mapping of the protected and plain cases
    chk_multi_key: assert property (
        d_valid && !field_start && in_seg && s_q.ciph && s_q.dbl_l && s_q.fmt_l == KSM_FMT_MULTI && in_b &&
        {4'h0, s_q.sub} < KSM_SUB_DATA |=> q_bit == ($past(d_bit) ^ $past(ks_bit)))
        else $error("subfield data not keyed");
    chk_single_key: assert property (
        d_valid && !field_start && in_seg && s_q.ciph && s_q.dbl_l && s_q.fmt_l == KSM_FMT_SINGLE && in_b &&
        b_idx < KSM_SINGLE_DATA |=> q_bit == ($past(d_bit) ^ $past(ks_bit)))
        else $error("single subfield data not keyed");
    chk_half_resume: assert property (
        d_valid && !field_start && in_seg && s_q.ciph && !s_q.dbl_l && s_q.fmt_l == KSM_FMT_MULTI && in_b &&
        b_idx >= KSM_SUB_LEN |=> q_bit == ($past(d_bit) ^ $past(ks_bit)))
        else $error("half slot bits past check not keyed");
    chk_x_clear: assert property (
        d_valid && !field_start && !in_seg |=> q_bit == $past(d_bit))
        else $error("bit past segment modified");
    chk_plain_mode: assert property (
        d_valid && !field_start && !s_q.ciph |=> q_bit == $past(d_bit))
        else $error("clear mode bit modified");
    chk_q_follow: assert property (
        d_valid && !field_start |=> q_valid)
        else $error("accepted bit not returned");
    chk_ctrl_write: assert property (
        psel && penable && pwrite && paddr == KSM_CTRL_OFS |=> {s_q.fmt, s_q.dbl, s_q.en} == 4'($past(pwdata)))
        else $error("mode write did not land");

    cov_double_multi: cover property (field_done && s_q.dbl_l && s_q.fmt_l == KSM_FMT_MULTI);
    cov_two_fields: cover property (field_start ##[1:1000] field_start && ks_segment);
    cov_half_long: cover property (field_done && !s_q.dbl_l && s_q.blen_l > KSM_SUB_LEN);
    cov_single_dbl: cover property (field_done && s_q.dbl_l && s_q.fmt_l == KSM_FMT_SINGLE);
    cov_plain_tail: cover property (field_done && !s_q.tail_l && s_q.ciph);
endmodule

// [ksm_keygen_model.sv]
// Key stream generator model facing the mapper's key side.
// Assumes field_start restarts the segment and ks_take consumes one key bit.
`timescale 1ns/1ps
module ksm_keygen_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Mapper side
    input wire logic field_start,
    input wire logic ks_take,
    input wire logic ks_segment,
    output logic ks_bit
);
    logic [10:0] cnt_q;
    logic tog_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 11'h000;
            tog_q <= 1'b0;
        end else begin
            tog_q <= ~tog_q;
            if (field_start) begin
                cnt_q <= 11'h000;
            end else if (ks_take) begin
                cnt_q <= cnt_q + 11'h001;
            end
        end
    end
    // Key not taken toggles, so a leak past the segment end shows up
    assign ks_bit = ks_take ? (ks_segment ^ cnt_q[0] ^ cnt_q[3] ^ cnt_q[6]) : tog_q;
endmodule

// [ksm_mapper_test.sv]
// Self-checking bench for the key stream field XOR mapper.
// Assumes zero-wait APB and one key bit per D-field bit from the model.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
    $display("unexpected %s expected %0h seen %0h", what, exp, got); end end
module ksm_mapper_test;
    import ksm_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, q_valid, q_bit, field_done, ks_bit, ks_take, ks_segment;
    logic frame_start = 0, field_start = 0, tail_ct = 0, d_valid = 0, d_bit = 0;
    logic [3:0] bearer_id = 4'h0;
    logic [31:0] init_value;
    logic [3:0] cur_ctrl = 4'h0;
    logic cur_tail = 0, cur_seg = 0;
    int cur_j = 80, exp_i = 0, done_n = 0, fails = 0, samples_checked = 0;
    ksm_mapper u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_start(frame_start), .field_start(field_start), .tail_ct(tail_ct), .bearer_id(bearer_id),
        .d_valid(d_valid), .d_bit(d_bit), .q_valid(q_valid), .q_bit(q_bit), .field_done(field_done),
        .ks_bit(ks_bit), .ks_take(ks_take), .ks_segment(ks_segment), .init_value(init_value));
    ksm_keygen_model u_key (.pclk(pclk), .presetn(presetn), .field_start(field_start), .ks_take(ks_take),
        .ks_segment(ks_segment), .ks_bit(ks_bit));
    initial forever #5 pclk = ~pclk;
    function automatic logic dpat(int i);
        return i[1] ^ i[4] ^ i[7];
    endfunction
    function automatic logic exp_bit(int i);
        int b;
        int len;
        logic k;
        b = i - 40;
        len = cur_ctrl[1] ? 840 : 40 + cur_j;
        case (cur_ctrl[3:2])
            2'h0: k = 1'b1;
            2'h1: k = cur_ctrl[1] ? (b % 80 < 64) : (b < 64 || b >= 80);
            2'h2: k = b < 768;
            default: k = 1'b0;
        endcase
        k = cur_ctrl[0] && i < len && (i < 40 ? cur_tail : k);
        return dpat(i) ^ (k & (cur_seg ^ i[0] ^ i[3] ^ i[6]));
    endfunction
    // Every returned bit is judged against the expected mapping
    always @(posedge pclk) begin
        if (q_valid === 1'b1) begin
            `CHK("q_bit", exp_bit(exp_i), q_bit)
            exp_i++;
        end
        if (field_done === 1'b1) done_n++;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
        if (pready !== 1'b1) begin fails++; final_report(); end
    endtask
    task automatic set_mode(input logic [3:0] ctrl, input int j);
        apb(1, KSM_CTRL_OFS, {28'h0, ctrl});
        apb(1, KSM_BLEN_OFS, j);
        cur_ctrl = ctrl;
        cur_j = j;
    endtask
    // One D-field: field_start, n bits back to back, then drain
    task automatic run_field(input logic fs, input logic tail, input int n);
        int d0;
        logic [3:0] bid;
        d0 = done_n;
        bid = {fs, tail, n[3:2]};
        @(posedge pclk);
        frame_start <= fs; field_start <= 1; tail_ct <= tail; bearer_id <= bid;
        exp_i = 0; cur_tail = tail; cur_seg = !fs;
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            frame_start <= 0; field_start <= 0; d_valid <= 1; d_bit <= dpat(i);
            if (i == 1) begin
                `CHK("ks_segment", !fs, ks_segment)
                `CHK("init_value", {bid, 24'h000015, 4'h3}, init_value)
            end
        end
        @(posedge pclk);
        d_valid <= 0;
        repeat (3) @(posedge pclk);
        `CHK("bits returned", n, exp_i)
        `CHK("field_done", d0 + 1, done_n)
    endtask
    task automatic t_regs();
        apb(0, KSM_BLEN_OFS, 32'h0);
        `CHK("blen reset", 32'h0000_0050, rd)
        apb(0, 8'h10, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        apb(1, KSM_FRAME_OFS, 32'h0000_0153);
        apb(0, KSM_FRAME_OFS, 32'h0);
        `CHK("frame", 32'h0000_0153, rd)
        $display("test regs done");
    endtask
    task automatic t_half();
        set_mode(4'h1, 80);
        run_field(1, 1, 124);
        run_field(0, 0, 124);
        set_mode(4'h5, 160);
        run_field(1, 1, 204);
        run_field(0, 1, 204);
        set_mode(4'h0, 80);
        run_field(1, 1, 124);
        $display("test half done");
    endtask
    task automatic t_double();
        for (int f = 0; f < 4; f++) begin
            set_mode({f[1:0], 2'b11}, 80);
            run_field(1, 1, 844);
            run_field(0, f[0], 844);
        end
        apb(0, KSM_STAT_OFS, 32'h0);
        `CHK("status", 32'h0001_000D, rd)
        $display("test double done");
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        t_regs();
        t_half();
        t_double();
        final_report();
    end
endmodule
